// [rtl/sipol_consts.vh]
/*
 constants for the serial-in parallel-out latch: widths, fifo depth,
 clear values and synchroniser reset values.
 assumes it is included by bare name from files under rtl/.

 // What this block does
 // (R1) eight-stage shift register feeds eight-bit store
 // (R2) separate clocks and overriding clears per register
 // (R3) both clocks act on rising edges only
 // (R4) common clocks: store trails shift by one
 // (R5) shift clear low forces all stages zero
 // (R6) shift edge: first takes input, others ripple
 // (R7) falling shift edge leaves shift register unchanged
 // (R8) store clear low forces store to zero
 // (R9) store edge loads all eight shift bits
 // (R10) falling store edge leaves store unchanged
 // (R11) cascade output feeds next device's serial input
 // (R12) outputs continuously show store and last stage
 // (R13) host shifts eight bits then one store edge
*/
`ifndef SIPOL_CONSTS_VH
`define SIPOL_CONSTS_VH

`define SIPOL_WIDTH 8
`define SIPOL_FIFO_DEPTH 8
`define SIPOL_FIFO_AW 3
`define SIPOL_CLR_VAL 8'h00
`define SIPOL_SYNC_RST 1'b0
`define SIPOL_CLR_SYNC_RST 1'b0

`endif

// [rtl/sipol_sync.v]
/*
 two-flop synchroniser for a bundle of asynchronous pins.
 assumes i_sys_clk is the block clock and i_rst is asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sipol_consts.vh"

module sipol_sync #(
  parameter W = 5,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // first flop read only by the second
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule
`default_nettype wire

// [rtl/sipol_fifo.v]
/*
 small synchronous fifo with valid/ready on both sides.
 assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sipol_consts.vh"

module sipol_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_flush,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  // honest full/empty from the fill count
  assign o_in_ready = (cnt_q != DEPTH[AW:0]);
  assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  assign o_out_data = mem_q[rd_q];

  // storage array, no reset needed
  always @(posedge i_sys_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  // pointers and count
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else if (i_flush) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule
`default_nettype wire

// [rtl/sipol_top.v]
/*
 serial-in parallel-out shift register with storage register, rebuilt
 on the system clock. the host's clocks and clears arrive as pins,
 pass two flops, and the clocks are edge-detected here.
 assumes the pin clocks are much slower than i_sys_clk (80 ns in the
 bench against 10 ns) so every pin level lasts several system cycles.
 shifted bytes pass through a small fifo before the store register;
 a store with an empty fifo loads the live shift register.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sipol_consts.vh"

module sipol_top (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_serial_in,
  input wire i_shift_clock,
  input wire i_shift_clear_n,
  input wire i_store_clock,
  input wire i_store_clear_n,
  output wire [`SIPOL_WIDTH-1:0] o_parallel_out,
  output wire o_cascade_out,
  output wire o_fifo_full
);

  localparam W = `SIPOL_WIDTH;

  // edge detector states
  localparam [1:0] ST_LOW = 2'b00;
  localparam [1:0] ST_HIGH = 2'b01;

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers

  wire [4:0] pins_sync;
  wire ser_s;
  wire sclk_s;
  wire sclr_n_s;
  wire rclk_s;
  wire store_clear_n_n_s;

  // clears reset to asserted so nothing moves until the pins are seen
  sipol_sync #(
    .W(5),
    .RST_VAL(5'h00)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_async({i_serial_in, i_shift_clock, i_shift_clear_n,
              i_store_clock, i_store_clear_n}),
    .o_sync(pins_sync)
  );

  assign ser_s = pins_sync[4];
  assign sclk_s = pins_sync[3];
  assign sclr_n_s = pins_sync[2];
  assign rclk_s = pins_sync[1];
  assign store_clear_n_n_s = pins_sync[0];

  ////////////////////////////////////////////////////////////////////
  // edge detection on the synchronised clocks

  reg [1:0] sclk_st_q;
  reg [1:0] sclk_st_d;
  reg [1:0] rclk_st_q;
  reg [1:0] rclk_st_d;
  reg sclk_rise;
  reg rclk_rise;

  // returns next detector state for a given level
  function [1:0] edge_next;
    input [1:0] st;
    input lvl;
    begin
      case (st)
        ST_LOW: edge_next = lvl ? ST_HIGH : ST_LOW;
        ST_HIGH: edge_next = lvl ? ST_HIGH : ST_LOW;
        default: edge_next = ST_LOW;
      endcase
    end
  endfunction

  // rising edge only; falling edges produce no event
  always @* begin
    sclk_st_d = edge_next(sclk_st_q, sclk_s);
    rclk_st_d = edge_next(rclk_st_q, rclk_s);
    sclk_rise = (sclk_st_q == ST_LOW) & sclk_s; // R3 R7
    rclk_rise = (rclk_st_q == ST_LOW) & rclk_s; // R3 R10
  end

  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_st_q <= ST_LOW;
      rclk_st_q <= ST_LOW;
    end else begin
      sclk_st_q <= sclk_st_d;
      rclk_st_q <= rclk_st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // shift register

  reg [W-1:0] shift_q;
  reg [W-1:0] shift_d;
  reg [2:0] bit_cnt_q;
  reg [2:0] bit_cnt_d;
  wire byte_done;

  // clear overrides the shift edge
  always @* begin
    shift_d = shift_q;
    bit_cnt_d = bit_cnt_q;
    if (!sclr_n_s) begin
      shift_d = `SIPOL_CLR_VAL; // R2 R5
      bit_cnt_d = 3'h0;
    end else if (sclk_rise) begin
      shift_d = {shift_q[W-2:0], ser_s}; // R1 R6
      bit_cnt_d = bit_cnt_q + 3'h1;
    end
  end

  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      shift_q <= `SIPOL_CLR_VAL;
      bit_cnt_q <= 3'h0;
    end else begin
      shift_q <= shift_d;
      bit_cnt_q <= bit_cnt_d;
    end
  end

  // eighth shift completes a byte (host order R13)
  assign byte_done = sclr_n_s & sclk_rise & (bit_cnt_q == 3'h7); // R13

  ////////////////////////////////////////////////////////////////////
  // byte fifo between shift and store

  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [W-1:0] fifo_out_data;
  wire fifo_pop;

  // a cleared shift register drops queued bytes; a store clear keeps them
  sipol_fifo #(
    .WIDTH(W),
    .DEPTH(`SIPOL_FIFO_DEPTH),
    .AW(`SIPOL_FIFO_AW)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_flush(~sclr_n_s),
    .i_in_valid(byte_done),
    .o_in_ready(fifo_in_ready),
    .i_in_data(shift_d),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_out_data)
  );

  assign o_fifo_full = ~fifo_in_ready;
  assign fifo_pop = store_clear_n_n_s & rclk_rise & fifo_out_valid;

  ////////////////////////////////////////////////////////////////////
  // storage register

  reg [W-1:0] store_q;
  reg [W-1:0] store_d;

  // store edge takes the queued byte, else the pre-edge shift value; clear wins
  always @* begin
    store_d = store_q;
    if (!store_clear_n_n_s) begin
      store_d = `SIPOL_CLR_VAL; // R2 R8
    end else if (rclk_rise) begin
      if (fifo_out_valid) begin
        store_d = fifo_out_data; // R9
      end else begin
        store_d = shift_q; // R4 R9
      end
    end
  end

  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      store_q <= `SIPOL_CLR_VAL;
    end else begin
      store_q <= store_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs from flops

  assign o_parallel_out = store_q; // R12
  assign o_cascade_out = shift_q[W-1]; // R11 R12

endmodule
`default_nettype wire

// [testbench/sipol_monitor.sv]
/* port checker for sipol_top; assumes pin clock phases of four system cycles */
`timescale 1ns/1ps
`default_nettype none
module sipol_monitor (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_shift_clock,
  input wire logic i_shift_clear_n,
  input wire logic i_store_clock,
  input wire logic i_store_clear_n,
  input wire logic [7:0] o_parallel_out,
  input wire logic o_cascade_out,
  input wire logic o_fifo_full
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // one high phase then one low phase of a pin clock, clear off
  sequence s_sh;
    (i_shift_clock && i_shift_clear_n)[*4] ##1 (!i_shift_clock && i_shift_clear_n)[*4];
  endsequence
  sequence s_st;
    (i_store_clock && i_store_clear_n)[*4] ##1 (!i_store_clock && i_store_clear_n)[*4];
  endsequence
  ////////////////////////////////////////
  // outputs tied to their causes at the pins
  AST_RST_ZERO: assert property ($fell(i_rst) |-> !o_cascade_out && o_parallel_out == 8'h00)
    else $error("outputs not zero after reset");
  AST_SH_CLR: assert property ((!i_shift_clear_n)[*6] |-> !o_cascade_out)
    else $error("cascade not cleared");
  AST_ST_CLR: assert property ((!i_store_clear_n)[*6] |-> o_parallel_out == 8'h00)
    else $error("store not cleared");
  AST_FLUSH: assert property ((!i_shift_clear_n)[*6] |-> !o_fifo_full)
    else $error("queue not flushed");
  AST_SH_FALL: assert property (s_sh |-> o_cascade_out == $past(o_cascade_out, 3))
    else $error("cascade moved on falling edge");
  AST_ST_FALL: assert property (s_st |-> o_parallel_out == $past(o_parallel_out, 3))
    else $error("store moved on falling edge");
  AST_SH_IDLE: assert property ((!i_shift_clock && i_shift_clear_n)[*8] |-> $stable(o_cascade_out))
    else $error("cascade moved without edge");
  AST_ST_LAT: assert property ($rose(i_store_clock) && i_store_clear_n |=> $stable(o_parallel_out)[*2])
    else $error("store loaded too early");
endmodule
`default_nettype wire

// [testbench/sipol_host.sv]
/* host model driving the pins of sipol_top; assumes a 10 ns system clock */
`timescale 1ns/1ps
`default_nettype none
module sipol_host (
  input wire logic i_sys_clk,
  output logic o_din,
  output logic o_sh_clk,
  output logic o_sh_clr_n,
  output logic o_st_clk,
  output logic o_st_clr_n
);
  // idle levels: clocks low, clears off
  initial begin
    {o_din, o_sh_clk, o_st_clk} = 3'h0;
    {o_sh_clr_n, o_st_clr_n} = 2'h3;
  end
  // one bit per 80 ns pin clock, data set in the low phase
  task automatic bit1(input logic b, input logic tie);
    @(posedge i_sys_clk) o_din <= b;
    repeat (3) @(posedge i_sys_clk);
    o_sh_clk <= 1'b1;
    o_st_clk <= tie;
    repeat (4) @(posedge i_sys_clk);
    o_sh_clk <= 1'b0;
    o_st_clk <= 1'b0;
  endtask
  // eight bits, the one bound for the last stage first
  task automatic byte8(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) bit1(v[i], 1'b0);
  endtask
  // lone store pulse
  task automatic store();
    @(posedge i_sys_clk) o_st_clk <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    o_st_clk <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
  endtask
  // clear pulse: sel 0 shift side, 1 store side
  task automatic clr(input logic sel);
    @(posedge i_sys_clk) {o_sh_clr_n, o_st_clr_n} <= sel ? 2'h2 : 2'h1;
    repeat (6) @(posedge i_sys_clk);
    {o_sh_clr_n, o_st_clr_n} <= 2'h3;
    repeat (4) @(posedge i_sys_clk);
  endtask
endmodule
`default_nettype wire

// [testbench/test_serial_in_parallel_out_latch8.sv]
/* bench for sipol_top with host model; assumes a 100 MHz system clock */
`timescale 1ns/1ps
`default_nettype none
module test_serial_in_parallel_out_latch8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  wire din, shclk, shclr_n, stclk, stclr_n, casc, full;
  wire [7:0] par;
  int n_fail = 0;
  int num_checks = 0;
  logic [7:0] v;
  always #5 clk = ~clk;
  sipol_host u_host (.i_sys_clk(clk), .o_din(din), .o_sh_clk(shclk), .o_sh_clr_n(shclr_n),
    .o_st_clk(stclk), .o_st_clr_n(stclr_n));
  sipol_top i_dut (.i_sys_clk(clk), .i_rst(rst), .i_serial_in(din), .i_shift_clock(shclk),
    .i_shift_clear_n(shclr_n), .i_store_clock(stclk), .i_store_clear_n(stclr_n),
    .o_parallel_out(par), .o_cascade_out(casc), .o_fifo_full(full));
  // compare off the clock edge and count
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    @(negedge clk);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  ////////////////////////////////////////
  task automatic t_byte();
    u_host.clr(1'b0);
    u_host.byte8(8'ha5);
    chk("cascade", 8'h01, {7'h00, casc});
    u_host.store();
    chk("parallel", 8'ha5, par);
    $display("t_byte done");
  endtask
  task automatic t_clear();
    u_host.clr(1'b1);
    chk("parallel", 8'h00, par);
    chk("cascade", 8'h01, {7'h00, casc});
    u_host.clr(1'b0);
    chk("cascade", 8'h00, {7'h00, casc});
    u_host.store();
    chk("parallel", 8'h00, par);
    $display("t_clear done");
  endtask
  task automatic t_tied();
    repeat (3) u_host.bit1(1'b1, 1'b1);
    chk("parallel", 8'h03, par);
    u_host.store();
    chk("parallel", 8'h07, par);
    $display("t_tied done");
  endtask
  task automatic t_fifo();
    u_host.clr(1'b0);
    v = 8'h1d;
    repeat (9) begin
      u_host.byte8(v);
      v = v + 8'h1d;
    end
    chk("full", 8'h01, {7'h00, full});
    v = 8'h1d;
    repeat (8) begin
      u_host.store();
      chk("parallel", v, par);
      v = v + 8'h1d;
    end
    chk("full", 8'h00, {7'h00, full});
    u_host.store();
    chk("parallel", 8'h05, par);
    $display("t_fifo done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_byte();
    t_clear();
    t_tied();
    t_fifo();
    complete_run();
  end
endmodule
bind sipol_top sipol_monitor u_mon (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_shift_clock(i_shift_clock), .i_shift_clear_n(i_shift_clear_n),
  .i_store_clock(i_store_clock), .i_store_clear_n(i_store_clear_n),
  .o_parallel_out(o_parallel_out), .o_cascade_out(o_cascade_out), .o_fifo_full(o_fifo_full));
`default_nettype wire
